//--- logic/addr_compare.sv
// Purpose: one address comparator with direction and size qualification
// Assumes: bus fields stable within the cycle
// Notes:   ordering outputs serve the range pair
`timescale 1ns/10ps
`default_nettype none
module addr_compare (
   input  wire dbg_match_pkg::comp_ctl_s ctl,       // comparator control
   input  wire dbg_match_pkg::addr_t     ref_addr,  // programmed address
   input  wire dbg_match_pkg::bus_s      bus,       // observed bus cycle
   input  wire logic                     word_gran, // ignore address bit 0
   input  wire logic                     use_size,  // size qualification allowed
   output logic                          hit_eq,    // address equal
   output logic                          hit_ge,    // address at or above
   output logic                          hit_le,    // address at or below
   output logic                          qual_ok    // direction and size accepted
);
   wire dbg_match_pkg::addr_t bus_a;
   wire dbg_match_pkg::addr_t ref_a;
   wire                       dir_ok;
   wire                       size_ok;

   assign bus_a   = word_gran ? {bus.addr[17:1], 1'b0} : bus.addr;
   assign ref_a   = word_gran ? {ref_addr[17:1], 1'b0} : ref_addr;
   assign hit_eq  = bus_a == ref_a;
   assign hit_ge  = bus_a >= ref_a;
   assign hit_le  = bus_a <= ref_a;
   assign dir_ok  = !ctl.direction_qualify_enable || (ctl.rw == bus.read);
   assign size_ok = !use_size || !ctl.size_qualify_enable || (ctl.size_select == !bus.word);
   assign qual_ok = dir_ok && size_ok;
endmodule
`default_nettype wire

//--- logic/data_compare.sv
// Purpose: masked data bus comparison of the first comparator
// Assumes: lower-address byte on data[15:8]
// Notes:   byte accesses still see the low lane, so a low mask may match by accident
`timescale 1ns/10ps
`default_nettype none
module data_compare (
   input  wire logic [15:0] data,     // bus data
   input  wire logic [15:0] cmp,      // {high compare, low compare}
   input  wire logic [15:0] mask,     // {high mask, low mask}
   input  wire logic        not_equal_data_select,      // match on difference
   output logic             data_ok   // data qualification passed
);
   wire [15:0] diff;

   assign diff    = (data ^ cmp) & mask;
   assign data_ok = not_equal_data_select ? |diff : ~|diff;
endmodule
`default_nettype wire

//--- logic/dbg_match_map.svh
// Purpose: offsets, field positions and reset values of the debug comparator match block
// Assumes: 8-bit register port, byte addresses
// Notes:   included by bare name
`ifndef DBG_MATCH_MAP_SVH
`define DBG_MATCH_MAP_SVH

`define OFS_CONTROL_FIRST   8'h00
`define OFS_STATUS          8'h01
`define OFS_RANGE_CONTROL   8'h02
`define OFS_STATE_CTL1      8'h03
`define OFS_DATA_CMP_HIGH   8'h08
`define OFS_DATA_CMP_LOW    8'h09
`define OFS_DATA_MASK_HIGH  8'h0A
`define OFS_DATA_MASK_LOW   8'h0B
`define OFS_COMP_BLOCK      4'h1
`define OFS_COMP_CTL        2'h0
`define OFS_COMP_ADDR_H     2'h1
`define OFS_COMP_ADDR_M     2'h2
`define OFS_COMP_ADDR_L     2'h3

`define BIT_ARM             7
`define BIT_TRIGGER         6
`define BIT_BRK_ENABLE      5
`define BIT_BEGIN_ALIGN     4

`define RANGE_OFF           2'h0
`define RANGE_INSIDE        2'h1
`define RANGE_OUTSIDE       2'h2

`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
`define RST_ADDR            18'h00000

`endif

//--- logic/dbg_match_pkg.sv
// Purpose: types shared by the debug comparator match block
// Assumes: 18-bit address bus, 16-bit data bus
// Notes:   constants live in dbg_match_map.svh
package dbg_match_pkg;

   typedef logic [17:0] addr_t;

   typedef struct packed {
      logic        size_select;     // 1 = byte
      logic        tag;
      logic        breakpoint_on_match;
      logic        rw;              // 1 = read
      logic        direction_qualify_enable;
      logic        size_qualify_enable;
      logic        not_equal_data_select;
      logic        enable;
   } comp_ctl_s;

   typedef struct packed {
      addr_t       addr;
      logic [15:0] data;            // [15:8] byte at addr, [7:0] byte at addr+1
      logic        valid;
      logic        read;
      logic        word;
      logic        fetch;
      logic        bdm_access;
   } bus_s;

   typedef enum logic [2:0] {
      ST_DISARMED,
      ST_ONE,
      ST_TWO,
      ST_THREE,
      ST_FINAL
   } seq_state_e;

endpackage

//--- logic/debug_comparator_match.sv
// Purpose: comparator match logic, range pair, tagging and trigger of the debug module
// Assumes: core bus and tag hits synchronous to ref_clk
// Notes:   register port reads answer one cycle after the strobe
`include "dbg_match_map.svh"
`timescale 1ns/10ps
`default_nettype none
module debug_comparator_match (
   input  wire logic                   ref_clk,        // system clock
   input  wire logic                   rst,            // synchronous reset, high
   input  wire logic [7:0]             reg_addr,       // register address
   input  wire logic [7:0]             reg_wdata,      // register write data
   input  wire logic                   reg_wr,         // write strobe
   input  wire logic                   reg_rd,         // read strobe
   output logic [7:0]                  reg_rdata,      // read data, cycle after strobe
   input  wire dbg_match_pkg::bus_s    bus,            // core bus cycle
   input  wire logic                   bdm_active,     // background debug mode active
   input  wire logic [2:0]             tag_hit,        // core: tagged opcode executes
   output logic [2:0]                  tag_set,        // tag the fetched opcode per channel
   output logic                        breakpoint_req, // breakpoint request pulse
   output logic                        trace_trigger,  // final state entered pulse
   output dbg_match_pkg::seq_state_e   seq_state       // sequencer state
);
   dbg_match_pkg::comp_ctl_s ctl [0:2];
   dbg_match_pkg::addr_t     cmp_addr [0:2];
   logic [15:0]              data_cmp;
   logic [15:0]              data_mask;
   logic [1:0]               range_mode;
   logic                     brk_enable;
   logic                     begin_align;
   logic [5:0]               state_ctl [0:2];
   logic [2:0]               match_flag;
   logic [2:0]               forced_q;

   wire [2:0]  hit_eq;
   wire [2:0]  hit_ge;
   wire [2:0]  hit_le;
   wire [2:0]  qual_ok;
   wire        data_ok;
   wire        range_on;
   wire        range_tag;
   wire        watching;
   wire        inside_hit;
   wire        outside_hit;
   wire        range_hit;
   wire [2:0]  single_hit;
   wire [2:0]  ch_hit;
   wire [2:0]  ch_tag;
   wire [2:0]  ch_brk;
   wire [2:0]  event_now;
   wire        wr_ctl;
   wire        immediate_trigger_wr;
   wire        armed;
   wire [1:0]  pick;
   wire        any_event;
   wire [1:0]  next_sel;
   wire dbg_match_pkg::seq_state_e next_state;
   wire        next_bkpt;
   wire [7:0]  rd_value;
   wire [5:0]  cur_ctl;
   wire [7:0]  status_value;

   // next-state code of one channel from a state control byte
   function automatic dbg_match_pkg::seq_state_e next_of(input logic [1:0] code);
      case (code)
         2'h0:    next_of = dbg_match_pkg::ST_ONE;
         2'h1:    next_of = dbg_match_pkg::ST_TWO;
         2'h2:    next_of = dbg_match_pkg::ST_THREE;
         default: next_of = dbg_match_pkg::ST_FINAL;
      endcase
   endfunction

   // register address decode of one comparator byte
   function automatic logic comp_sel(input logic [7:0] a, input logic [1:0] idx, input logic [1:0] part);
      comp_sel = (a[7:4] == `OFS_COMP_BLOCK) && (a[3:2] == idx) && (a[1:0] == part);
   endfunction

   // state control byte for the current state; states outside 1..3 use the first
   assign cur_ctl = (seq_state == dbg_match_pkg::ST_TWO)   ? state_ctl[1] :
                    (seq_state == dbg_match_pkg::ST_THREE) ? state_ctl[2] : state_ctl[0];

   // comparators
   assign range_on  = range_mode != `RANGE_OFF;
   assign range_tag = range_on && ctl[0].tag;
   assign armed     = seq_state != dbg_match_pkg::ST_DISARMED;
   assign watching  = armed && bus.valid && !bdm_active && !bus.bdm_access;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_comp
         addr_compare u_addr (
            .ctl       (ctl[gi]),
            .ref_addr  (cmp_addr[gi]),
            .bus       (bus),
            .word_gran (range_tag),
            .use_size  ((gi < 2) && !range_on),
            .hit_eq    (hit_eq[gi]),
            .hit_ge    (hit_ge[gi]),
            .hit_le    (hit_le[gi]),
            .qual_ok   (qual_ok[gi])
         );
         // tagged channels ignore direction, size and data
         assign single_hit[gi] = ctl[gi].enable && hit_eq[gi] &&
                                 (ctl[gi].tag || (qual_ok[gi] && (gi != 0 || data_ok)));
      end
   endgenerate

   data_compare u_data (
      .data    (bus.data),
      .cmp     (data_cmp),
      .mask    (data_mask),
      .not_equal_data_select     (ctl[0].not_equal_data_select),
      .data_ok (data_ok)
   );

   // range pair: first comparator gives lower limit, second the upper
   assign inside_hit  = hit_ge[0] && hit_le[1];
   assign outside_hit = !hit_ge[0] || !hit_le[1];
   assign range_hit   = ctl[0].enable && ctl[1].enable &&
                        ((range_mode == `RANGE_INSIDE) ? inside_hit :
                         (range_mode == `RANGE_OUTSIDE) ? outside_hit : 1'b0) &&
                        (ctl[0].tag || (qual_ok[0] && data_ok));

   assign ch_hit[0] = watching && (range_on ? range_hit : single_hit[0]);
   assign ch_hit[1] = watching && !range_on && single_hit[1];
   assign ch_hit[2] = watching && single_hit[2];
   assign ch_tag[0] = ctl[0].tag;
   assign ch_tag[1] = ctl[1].tag;
   assign ch_tag[2] = ctl[2].tag;
   assign ch_brk[0] = ctl[0].breakpoint_on_match;
   assign ch_brk[1] = ctl[1].breakpoint_on_match && !range_on;
   assign ch_brk[2] = ctl[2].breakpoint_on_match;

   // channel events: registered forced match or tag hit of a tagged channel
   assign event_now = armed && (seq_state != dbg_match_pkg::ST_FINAL) ?
                      (forced_q | (tag_hit & ch_tag)) : 3'h0;

   // winner: a channel pointing to final first, then the lowest number
   assign pick = (event_now[0] && (cur_ctl[1:0] == 2'h3)) ? 2'h0 :
                 (event_now[1] && (cur_ctl[3:2] == 2'h3)) ? 2'h1 :
                 (event_now[2] && (cur_ctl[5:4] == 2'h3)) ? 2'h2 :
                 event_now[0] ? 2'h0 :
                 event_now[1] ? 2'h1 : 2'h2;
   assign any_event = |event_now;
   assign next_sel  = (pick == 2'h0) ? cur_ctl[1:0] :
                      (pick == 2'h1) ? cur_ctl[3:2] : cur_ctl[5:4];

   // register writes
   assign wr_ctl  = reg_wr && (reg_addr == `OFS_CONTROL_FIRST);
   assign immediate_trigger_wr = wr_ctl && reg_wdata[`BIT_TRIGGER];

   // sequencer next state; trigger outranks every channel
   assign next_state =
      immediate_trigger_wr ? (reg_wdata[`BIT_BEGIN_ALIGN] ? dbg_match_pkg::ST_FINAL
                                             : dbg_match_pkg::ST_DISARMED) :
      (wr_ctl && !reg_wdata[`BIT_ARM]) ? dbg_match_pkg::ST_DISARMED :
      (wr_ctl && !armed) ? dbg_match_pkg::ST_ONE :
      (seq_state == dbg_match_pkg::ST_FINAL) ? dbg_match_pkg::ST_DISARMED :
      any_event ? next_of(next_sel) : seq_state;

   // end-aligned trigger, final-state exit and immediate channel breakpoints
   assign next_bkpt = (immediate_trigger_wr && !reg_wdata[`BIT_BEGIN_ALIGN]) ||
                      (!immediate_trigger_wr && (seq_state == dbg_match_pkg::ST_FINAL) && brk_enable) ||
                      (|(event_now & ch_brk));

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         seq_state      <= dbg_match_pkg::ST_DISARMED;
         forced_q       <= 3'h0;
         tag_set        <= 3'h0;
         breakpoint_req <= 1'b0;
         trace_trigger  <= 1'b0;
      end else begin
         seq_state      <= next_state;
         forced_q       <= ch_hit & ~ch_tag;
         tag_set        <= bus.fetch ? (ch_hit & ch_tag) : 3'h0;
         breakpoint_req <= next_bkpt;
         trace_trigger  <= (next_state == dbg_match_pkg::ST_FINAL) &&
                           (seq_state != dbg_match_pkg::ST_FINAL);
      end
   end

   // match flags: a transition sets, arming clears, set wins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         match_flag <= 3'h0;
      end else begin
         match_flag <= ((wr_ctl && reg_wdata[`BIT_ARM]) ? 3'h0 : match_flag) |
                       (any_event ? (3'h1 << pick) : 3'h0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         brk_enable  <= 1'b0;
         begin_align <= 1'b0;
         range_mode  <= `RANGE_OFF;
         data_cmp    <= `RST_WORD;
         data_mask   <= `RST_WORD;
      end else if (reg_wr) begin
         if (reg_addr == `OFS_CONTROL_FIRST) begin
            brk_enable  <= reg_wdata[`BIT_BRK_ENABLE];
            begin_align <= reg_wdata[`BIT_BEGIN_ALIGN];
         end
         if (reg_addr == `OFS_RANGE_CONTROL) begin
            range_mode <= reg_wdata[1:0];
         end
         if (reg_addr == `OFS_DATA_CMP_HIGH) begin
            data_cmp[15:8] <= reg_wdata;
         end
         if (reg_addr == `OFS_DATA_CMP_LOW) begin
            data_cmp[7:0] <= reg_wdata;
         end
         if (reg_addr == `OFS_DATA_MASK_HIGH) begin
            data_mask[15:8] <= reg_wdata;
         end
         if (reg_addr == `OFS_DATA_MASK_LOW) begin
            data_mask[7:0] <= reg_wdata;
         end
      end
   end

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_regs
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               ctl[gi]       <= dbg_match_pkg::comp_ctl_s'(`RST_BYTE);
               cmp_addr[gi]  <= `RST_ADDR;
               state_ctl[gi] <= 6'h00;
            end else if (reg_wr) begin
               if (comp_sel(reg_addr, 2'(gi), `OFS_COMP_CTL)) begin
                  ctl[gi] <= dbg_match_pkg::comp_ctl_s'(reg_wdata);
               end
               if (comp_sel(reg_addr, 2'(gi), `OFS_COMP_ADDR_H)) begin
                  cmp_addr[gi][17:16] <= reg_wdata[1:0];
               end
               if (comp_sel(reg_addr, 2'(gi), `OFS_COMP_ADDR_M)) begin
                  cmp_addr[gi][15:8] <= reg_wdata;
               end
               if (comp_sel(reg_addr, 2'(gi), `OFS_COMP_ADDR_L)) begin
                  cmp_addr[gi][7:0] <= reg_wdata;
               end
               if (reg_addr == (`OFS_STATE_CTL1 + 8'(gi))) begin
                  state_ctl[gi] <= reg_wdata[5:0];
               end
            end
         end
      end
   endgenerate

   // read mux; trigger reads as zero, unmapped addresses read zero
   assign status_value = {1'b0, match_flag, 1'b0, 3'(seq_state)};
   assign rd_value =
      (reg_addr == `OFS_CONTROL_FIRST)  ? {armed, 1'b0, brk_enable, begin_align, 4'h0} :
      (reg_addr == `OFS_STATUS)         ? status_value :
      (reg_addr == `OFS_RANGE_CONTROL)  ? {6'h00, range_mode} :
      (reg_addr == `OFS_STATE_CTL1)     ? {2'h0, state_ctl[0]} :
      (reg_addr == `OFS_STATE_CTL1 + 8'h01) ? {2'h0, state_ctl[1]} :
      (reg_addr == `OFS_STATE_CTL1 + 8'h02) ? {2'h0, state_ctl[2]} :
      (reg_addr == `OFS_DATA_CMP_HIGH)  ? data_cmp[15:8] :
      (reg_addr == `OFS_DATA_CMP_LOW)   ? data_cmp[7:0] :
      (reg_addr == `OFS_DATA_MASK_HIGH) ? data_mask[15:8] :
      (reg_addr == `OFS_DATA_MASK_LOW)  ? data_mask[7:0] :
      (reg_addr[7:4] != `OFS_COMP_BLOCK || reg_addr[3:2] == 2'h3) ? `RST_BYTE :
      (reg_addr[1:0] == `OFS_COMP_CTL)    ? 8'(ctl[reg_addr[3:2]]) :
      (reg_addr[1:0] == `OFS_COMP_ADDR_H) ? {6'h00, cmp_addr[reg_addr[3:2]][17:16]} :
      (reg_addr[1:0] == `OFS_COMP_ADDR_M) ? cmp_addr[reg_addr[3:2]][15:8] :
                                            cmp_addr[reg_addr[3:2]][7:0];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= `RST_BYTE;
      end else begin
         reg_rdata <= reg_rd ? rd_value : `RST_BYTE;
      end
   end
endmodule
`default_nettype wire

//--- sim/core_bus_model.sv
// Purpose: core side of the tagging handshake
// Assumes: tagged opcodes always reach execution
// Notes:   fixed fetch-to-execute delay stands in for the queue
`timescale 1ns/10ps
`default_nettype none
module core_bus_model #(
   parameter int EXEC_DELAY = 3        // fetch to execution, cycles
) (
   input  wire logic       ref_clk,    // system clock
   input  wire logic       rst,        // synchronous reset
   input  wire logic [2:0] tag_set,    // tagged fetch per channel
   output logic      [2:0] tag_hit     // tagged opcode executes
);
   logic [3*EXEC_DELAY-1:0] queue_line;
   assign tag_hit = queue_line[3*EXEC_DELAY-1 -: 3];
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         queue_line <= '0;
      end else begin
         queue_line <= (queue_line << 3) | (3*EXEC_DELAY)'(tag_set);
      end
   end
endmodule
`default_nettype wire

//--- sim/debug_comparator_match_bench.sv
// Purpose: self-checking bench of the debug comparator match block
// Assumes: one write strobe per call, core model answers tags
// Notes:   compare registers fixed at A5/5A, comparator A at 01234 except in the range cases
`timescale 1ns/10ps
`default_nettype none
module debug_comparator_match_bench;
   logic                      ref_clk;
   logic                      rst;
   logic                [7:0] reg_addr;
   logic                [7:0] reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic                [7:0] reg_rdata;
   logic                [7:0] rd_val;
   dbg_match_pkg::bus_s       bus;
   logic                      bdm_active;
   logic                [2:0] tag_hit;
   logic                [2:0] tag_set;
   logic                      breakpoint_req;
   logic                      trace_trigger;
   logic                      bp_seen;
   dbg_match_pkg::seq_state_e seq_state;
   int                        n_errors = 0;
   int                        checks = 0;
   int                        cycles = 0;
   debug_comparator_match u_debug_comparator_match (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus),
      .bdm_active(bdm_active), .tag_hit(tag_hit), .tag_set(tag_set), .breakpoint_req(breakpoint_req),
      .trace_trigger(trace_trigger), .seq_state(seq_state));
   core_bus_model #(.EXEC_DELAY(3)) u_core_bus_model (.ref_clk(ref_clk), .rst(rst), .tag_set(tag_set),
      .tag_hit(tag_hit));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (breakpoint_req === 1'b1) bp_seen <= 1'b1;
      if (cycles > 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask
   // released bus shows inverted values so stale data never matches by luck
   task automatic cyc(input dbg_match_pkg::addr_t a, input logic [15:0] d, input logic w, input logic f);
      @(posedge ref_clk);
      bus <= '{addr: a, data: d, valid: 1'b1, read: 1'b1, word: w, fetch: f, bdm_access: 1'b0};
      @(posedge ref_clk);
      bus <= '{addr: ~a, data: ~d, valid: 1'b0, read: 1'b0, word: ~w, fetch: 1'b0, bdm_access: 1'b0};
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic probe(input dbg_match_pkg::addr_t a, input logic [15:0] d, input logic w,
                        input dbg_match_pkg::seq_state_e exp);
      wr(8'h00, 8'h80);
      cyc(a, d, w, 1'b0);
      chk(8'(seq_state), 8'(exp));
      wr(8'h00, 8'h00);
   endtask
   task automatic dcase(input logic [7:0] ctl, input logic [15:0] msk, input logic [15:0] d, input logic w,
                        input logic hit);
      wr(8'h0A, msk[15:8]);
      wr(8'h0B, msk[7:0]);
      wr(8'h10, ctl);
      probe(18'h01234, d, w, hit ? dbg_match_pkg::ST_TWO : dbg_match_pkg::ST_ONE);
   endtask
   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      bus = '0;
      bdm_active = 1'b0;
      bp_seen = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      wr(8'h08, 8'hA5);
      wr(8'h09, 8'h5A);
      wr(8'h12, 8'h12);
      wr(8'h13, 8'h34);
      wr(8'h03, 8'h1D);
      dcase(8'h01, 16'h0000, 16'h0000, 1'b1, 1'b1);
      dcase(8'h01, 16'hFF00, 16'hA5FF, 1'b1, 1'b1);
      dcase(8'h01, 16'hFF00, 16'h5A5A, 1'b1, 1'b0);
      dcase(8'h05, 16'h00FF, 16'h005A, 1'b1, 1'b1);
      dcase(8'h05, 16'hFFFF, 16'hA55B, 1'b1, 1'b0);
      dcase(8'h85, 16'hFF00, 16'hA500, 1'b0, 1'b1);
      dcase(8'h85, 16'hFF00, 16'hA500, 1'b1, 1'b0);
      dcase(8'h03, 16'hFFFF, 16'hA55A, 1'b1, 1'b0);
      dcase(8'h03, 16'h0001, 16'hA55B, 1'b1, 1'b1);
      dcase(8'h03, 16'h0000, 16'h0000, 1'b1, 1'b0);
      // A: read, byte only; B: write only, tagged, breaking; range must ignore B bits and sizes
      wr(8'h10, 8'h9D);
      wr(8'h12, 8'h01);
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h69);
      wr(8'h16, 8'h02);
      wr(8'h17, 8'h00);
      bp_seen <= 1'b0;
      wr(8'h02, 8'h01);
      probe(18'h00150, 16'h0000, 1'b1, dbg_match_pkg::ST_TWO);
      probe(18'h00200, 16'h0000, 1'b1, dbg_match_pkg::ST_TWO);
      probe(18'h00250, 16'h0000, 1'b1, dbg_match_pkg::ST_ONE);
      wr(8'h02, 8'h02);
      probe(18'h00250, 16'h0000, 1'b1, dbg_match_pkg::ST_TWO);
      probe(18'h00150, 16'h0000, 1'b1, dbg_match_pkg::ST_ONE);
      wr(8'h12, 8'h00);
      probe(18'h00000, 16'h0000, 1'b1, dbg_match_pkg::ST_ONE);
      chk(8'(bp_seen), 8'h00);
      rd(8'h02);
      chk(rd_val, 8'h02);
      rd(8'h40);
      chk(rd_val, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h10, 8'h01);
      wr(8'h12, 8'h12);
      wr(8'h13, 8'h34);
      wr(8'h14, 8'h01);
      wr(8'h16, 8'h12);
      wr(8'h17, 8'h34);
      // final lasts one cycle, so the winner shows in the flags
      probe(18'h01234, 16'h0000, 1'b1, dbg_match_pkg::ST_DISARMED);
      rd(8'h01);
      chk(rd_val, 8'h20);
      bdm_active <= 1'b1;
      probe(18'h01234, 16'h0000, 1'b1, dbg_match_pkg::ST_ONE);
      bdm_active <= 1'b0;
      wr(8'h14, 8'h00);
      wr(8'h10, 8'h41);
      wr(8'h00, 8'h80);
      cyc(18'h01234, 16'h0000, 1'b0, 1'b1);
      chk(8'(seq_state), 8'(dbg_match_pkg::ST_ONE));
      repeat (2) @(posedge ref_clk);
      #1;
      chk(8'(seq_state), 8'(dbg_match_pkg::ST_TWO));
      wr(8'h00, 8'h00);
      wr(8'h00, 8'hD0);
      #1;
      chk(8'(trace_trigger), 8'h01);
      bp_seen <= 1'b0;
      wr(8'h00, 8'hC0);
      #1;
      chk(8'(breakpoint_req), 8'h01);
      chk(8'(seq_state), 8'(dbg_match_pkg::ST_DISARMED));
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- sim/debug_comparator_match_props.sv
// Purpose: port-level checks of the debug comparator match block
// Assumes: one ref_clk domain, synchronous active-high rst
// Notes:   bound to every instance of the block
`include "dbg_match_map.svh"
`timescale 1ns/10ps
`default_nettype none
module debug_comparator_match_props (
   input wire logic                      ref_clk,        // system clock
   input wire logic                      rst,            // synchronous reset
   input wire logic [7:0]                reg_addr,       // register address
   input wire logic [7:0]                reg_wdata,      // write data
   input wire logic                      reg_wr,         // write strobe
   input wire logic                      reg_rd,         // read strobe
   input wire logic [7:0]                reg_rdata,      // read data
   input wire dbg_match_pkg::bus_s       bus,            // core bus cycle
   input wire logic                      bdm_active,     // background debug
   input wire logic [2:0]                tag_hit,        // core tag hits
   input wire logic [2:0]                tag_set,        // fetch tags
   input wire logic                      breakpoint_req, // breakpoint pulse
   input wire logic                      trace_trigger,  // final entered pulse
   input wire dbg_match_pkg::seq_state_e seq_state       // sequencer state
);
   logic ctl_wr;
   assign ctl_wr = reg_wr && reg_addr == `OFS_CONTROL_FIRST;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_begin_immediate_trigger;
      ctl_wr && reg_wdata[`BIT_TRIGGER] && reg_wdata[`BIT_BEGIN_ALIGN];
   endsequence
   sequence s_end_immediate_trigger;
      ctl_wr && reg_wdata[`BIT_TRIGGER] && !reg_wdata[`BIT_BEGIN_ALIGN];
   endsequence
   sequence s_final_then_trace;
      (seq_state == dbg_match_pkg::ST_FINAL && trace_trigger) ##1 seq_state == dbg_match_pkg::ST_DISARMED;
   endsequence
   chk_reset_clear: assert property ($fell(rst) |-> seq_state == dbg_match_pkg::ST_DISARMED && tag_set == 3'h0)
      else $error("outputs not cleared after reset");
   chk_begin_trigger: assert property (s_begin_immediate_trigger |=> s_final_then_trace)
      else $error("begin trigger did not pass through final");
   chk_end_trigger: assert property (s_end_immediate_trigger |=> seq_state == dbg_match_pkg::ST_DISARMED && breakpoint_req)
      else $error("end trigger did not disarm with breakpoint");
   chk_arm_start: assert property (ctl_wr && reg_wdata[7:6] == 2'b10 && seq_state == dbg_match_pkg::ST_DISARMED
      |=> seq_state == dbg_match_pkg::ST_ONE)
      else $error("arm write did not enter state one");
   chk_trace_cause: assert property (trace_trigger
      |-> seq_state == dbg_match_pkg::ST_FINAL && $past(seq_state) != dbg_match_pkg::ST_FINAL)
      else $error("trace trigger without final state");
   chk_match_delay: assert property (seq_state == dbg_match_pkg::ST_TWO && $past(seq_state) != dbg_match_pkg::ST_TWO
      |-> $past(bus.valid, 2) || $past(tag_hit) != 3'h0)
      else $error("state two entered without a timed cause");
   chk_tag_fetch: assert property (tag_set != 3'h0 |-> $past(bus.valid && bus.fetch && !bdm_active))
      else $error("tag without a fetch cycle");
   chk_bdm_silent: assert property ($past(bdm_active) |-> tag_set == 3'h0)
      else $error("tag raised in background debug");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_bp_pulse: assert property (breakpoint_req |=> !breakpoint_req)
      else $error("breakpoint request longer than a cycle");
endmodule
bind debug_comparator_match debug_comparator_match_props u_props (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .bus(bus), .bdm_active(bdm_active), .tag_hit(tag_hit), .tag_set(tag_set),
   .breakpoint_req(breakpoint_req), .trace_trigger(trace_trigger), .seq_state(seq_state));
`default_nettype wire
